// ### rtl/ops_pkg.sv
// Constants, encodings and carrier types of the over-pressure supervisor.
package ops_pkg;

    // Clock and conversion timing.
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SAMPLE_HZ = 153_125;
    localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

    // Converter scaling: ten-bit result against the analog rail.
    localparam int unsigned ADC_W = 10;
    localparam logic [9:0] ADC_FULL = 10'h3FF;
    localparam longint unsigned ADC_STEPS = 1024;
    localparam longint unsigned VREF_UV = 5_000_000;
    localparam longint unsigned SLOPE_UV_PER_MMHG = 12_440;
    localparam longint unsigned ZERO_NOM_UV = 100_000;
    localparam longint unsigned ZERO_TOL_UV = 67_500;

    // Microvolts to converter steps, rounded down.
    function automatic logic [10:0] uv_to_counts(input longint unsigned uv);
        longint unsigned c;
        c = (uv * ADC_STEPS) / VREF_UV;
        return c[10:0];
    endfunction

    // Pressure in mmHg to converter steps above zero.
    function automatic logic [10:0] mmhg_to_counts(input longint unsigned mmhg);
        return uv_to_counts(mmhg * SLOPE_UV_PER_MMHG);
    endfunction

    // Pressure limits per mode and the inflated-cuff level.
    localparam longint unsigned ADULT_LIMIT_MMHG = 300;
    localparam longint unsigned PEDI_LIMIT_MMHG = 200;
    localparam longint unsigned NEO_LIMIT_MMHG = 150;
    localparam longint unsigned ACTIVE_MMHG = 5;
    localparam logic [10:0] ADULT_LIMIT_CNT = mmhg_to_counts(ADULT_LIMIT_MMHG);
    localparam logic [10:0] PEDI_LIMIT_CNT = mmhg_to_counts(PEDI_LIMIT_MMHG);
    localparam logic [10:0] NEO_LIMIT_CNT = mmhg_to_counts(NEO_LIMIT_MMHG);
    localparam logic [10:0] ACTIVE_CNT = mmhg_to_counts(ACTIVE_MMHG);
    localparam logic [10:0] ZERO_NOM_CNT = uv_to_counts(ZERO_NOM_UV);
    localparam logic [10:0] ZERO_LO_CNT = uv_to_counts(ZERO_NOM_UV - ZERO_TOL_UV);
    localparam logic [10:0] ZERO_HI_CNT = uv_to_counts(ZERO_NOM_UV + ZERO_TOL_UV);

    // Measurement duration limits per mode, in milliseconds.
    localparam logic [16:0] ADULT_DUR_MS = 17'h1D4C0;
    localparam logic [16:0] PEDI_DUR_MS = 17'h15F90;
    localparam logic [16:0] NEO_DUR_MS = 17'h0EA60;

    // Zero averaging and trip debounce, in samples.
    localparam logic [3:0] ZERO_SAMPLES = 4'h8;
    localparam int unsigned ZERO_SHIFT = 3;
    localparam logic [2:0] TRIP_SAMPLES = 3'h4;

    // Mode codes from the primary and state codes back to it.
    localparam logic [3:0] MODE_IDLE = 4'h0;
    localparam logic [3:0] MODE_ADULT = 4'h1;
    localparam logic [3:0] MODE_PEDI = 4'h2;
    localparam logic [3:0] MODE_NEO = 4'h3;
    localparam logic [3:0] CODE_NOT_READY = 4'h0;
    localparam logic [3:0] CODE_FAULT = 4'hE;
    localparam logic [3:0] CODE_SHUTDOWN = 4'hF;

    // Register offsets and fields.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_PRESSURE = 4'h4;
    localparam logic [3:0] REG_ZERO = 4'h5;
    localparam int unsigned CTRL_FORCE_TRIP = 0;
    localparam int unsigned IRQ_W = 6;
    localparam int unsigned IRQ_OVERPRESSURE = 0;
    localparam int unsigned IRQ_REF_FAIL = 1;
    localparam int unsigned IRQ_DURATION = 2;
    localparam int unsigned IRQ_ZERO_DONE = 3;
    localparam int unsigned IRQ_ZERO_FAULT = 4;
    localparam int unsigned IRQ_HOST_RESET = 5;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [5:0] IRQ_MASK_RST = 6'h00;

    // Supervisor states, Gray coded along wait, zero, armed, shutdown.
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_ZERO = 2'b01,
        ST_ARMED = 2'b11,
        ST_SHUTDOWN = 2'b10
    } sup_state_t;

    // Conversion request towards the converter.
    typedef struct packed {
        logic start;
        logic channel;
    } adc_req_t;

    // Conversion answer from the converter.
    typedef struct packed {
        logic done;
        logic [9:0] result;
    } adc_rsp_t;

    // One captured sample of a channel.
    typedef struct packed {
        logic valid;
        logic [9:0] value;
    } sample_t;

endpackage

// ### rtl/sample_sequencer.sv
// Free-running conversion pacer alternating pressure and reference channels.
`timescale 1ns/1ps
module sample_sequencer import ops_pkg::*; #(
    parameter int unsigned PERIOD = SAMPLE_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire adc_rsp_t i_adc_rsp,
    output adc_req_t o_adc_req,
    output sample_t o_press,
    output sample_t o_ref
);
    logic [11:0] period_reg;
    logic chan_reg;
    logic pend_reg;
    wire period_end = (period_reg == 12'(PERIOD - 1));

    // Conversions start at a fixed rate and never pause.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            period_reg <= 12'h000;
            chan_reg <= 1'b0;
            pend_reg <= 1'b0;
            o_adc_req <= '0;
        end else if (i_ce) begin
            period_reg <= period_end ? 12'h000 : period_reg + 12'h001;
            o_adc_req.start <= period_end;
            if (period_end) begin
                o_adc_req.channel <= chan_reg;
                pend_reg <= chan_reg;
                chan_reg <= ~chan_reg;
            end
        end
    end

    // Each result goes to the channel that was requested.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_press <= '0;
            o_ref <= '0;
        end else if (i_ce) begin
            o_press.valid <= i_adc_rsp.done && !pend_reg;
            o_ref.valid <= i_adc_rsp.done && pend_reg;
            if (i_adc_rsp.done && !pend_reg) begin
                o_press.value <= i_adc_rsp.result;
            end
            if (i_adc_rsp.done && pend_reg) begin
                o_ref.value <= i_adc_rsp.result;
            end
        end
    end
endmodule

// ### rtl/duration_timer.sv
// Millisecond measurement timer with a limit comparison.
`timescale 1ns/1ps
module duration_timer import ops_pkg::*; #(
    parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic [16:0] i_limit_ms,
    output logic o_expired
);
    logic [23:0] tick_reg;
    logic [16:0] ms_reg;
    wire tick = (tick_reg == 24'(TICK_CYCLES - 1));

    // Counts whole milliseconds while running and restarts when stopped.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_reg <= 24'h000000;
            ms_reg <= 17'h00000;
            o_expired <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                tick_reg <= 24'h000000;
                ms_reg <= 17'h00000;
            end else begin
                tick_reg <= tick ? 24'h000000 : tick_reg + 24'h000001;
                if (tick && ms_reg != 17'h1FFFF) begin
                    ms_reg <= ms_reg + 17'h00001;
                end
            end
            o_expired <= i_run && (ms_reg > i_limit_ms);
        end
    end
endmodule

// ### rtl/overpressure_safety_supervisor.sv
// Independent cuff over-pressure supervisor with latched power-cut shutdown.
//
// Overview of operation
// - Supervisor cuts switched actuator power on uncorrected over-pressure, independent of primary.
// - Shutdown latches; only a full power cycle leaves it.
// - Primary software or board reset never releases the supervisor's shutdown.
// - In shutdown the active-low power enable output is driven high.
// - Conversions at 153.125 kHz alternate transducer and reference, each pressure result checked against limit.
// - Primary presents mode; state code answers only when fault free, limited, zeroed.
// - Backup transducer zero is taken at 0 mmHg before the duration timer runs.
// - A full-scale reading of the 2.5 V reference means reference failure.
// - Backup pressure uses 12.44 mV per mmHg, about 100 mV at zero.
// - The supervisor never sleeps; monitoring runs continuously.
`timescale 1ns/1ps
module overpressure_safety_supervisor import ops_pkg::*; #(
    parameter int unsigned PERIOD = SAMPLE_CYCLES,
    parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_host_reset_n,
    input wire logic [3:0] i_meas_mode_code,
    output logic [3:0] o_supervisor_state_code,
    output logic o_power_cut_enable_n,
    output adc_req_t o_adc_req,
    input wire adc_rsp_t i_adc_rsp,
    input wire logic [3:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    output logic o_irq
);

    // Pressure limit above zero for a mode, in converter steps.
    function logic [10:0] mode_limit(input logic [3:0] mode);
        case (mode)
            MODE_PEDI: mode_limit = PEDI_LIMIT_CNT;
            MODE_NEO: mode_limit = NEO_LIMIT_CNT;
            default: mode_limit = ADULT_LIMIT_CNT;
        endcase
    endfunction

    // Measurement duration limit for a mode, in milliseconds.
    function logic [16:0] mode_duration(input logic [3:0] mode);
        case (mode)
            MODE_PEDI: mode_duration = PEDI_DUR_MS;
            MODE_NEO: mode_duration = NEO_DUR_MS;
            default: mode_duration = ADULT_DUR_MS;
        endcase
    endfunction

    // True for a mode code that asks for a measurement.
    function logic mode_known(input logic [3:0] mode);
        mode_known = (mode == MODE_ADULT) || (mode == MODE_PEDI) || (mode == MODE_NEO);
    endfunction

    sup_state_t state_reg;
    sup_state_t state_next;
    logic [3:0] mode_reg;
    logic [9:0] zero_reg;
    logic [12:0] zero_acc_reg;
    logic [3:0] zero_cnt_reg;
    logic zero_fault_reg;
    logic [2:0] trip_cnt_reg;
    logic [3:0] cause_reg;
    logic [9:0] last_press_reg;
    logic host_rst_prev_reg;
    logic [15:0] ctrl_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_events;
    sample_t press;
    sample_t refs;
    logic dur_expired;

    // Converter pacing and channel steering.
    sample_sequencer #(
        .PERIOD(PERIOD)
    ) u_seq (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_adc_rsp(i_adc_rsp),
        .o_adc_req(o_adc_req),
        .o_press(press),
        .o_ref(refs)
    );

    // Limit checks; before arming the adult limit at nominal zero applies.
    wire armed = (state_reg == ST_ARMED);
    wire [10:0] base = armed ? {1'b0, zero_reg} : ZERO_NOM_CNT;
    wire [10:0] active_limit = armed ? mode_limit(mode_reg) : ADULT_LIMIT_CNT;
    wire [10:0] trip_thresh = base + active_limit;
    wire [10:0] inflate_thresh = base + ACTIVE_CNT;
    wire over_sample = press.valid && ({1'b0, press.value} > trip_thresh);
    wire cuff_inflated = ({1'b0, last_press_reg} > inflate_thresh);

    // Duration timer runs once zeroed and with the cuff inflated.
    duration_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_dur (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_run(armed && cuff_inflated),
        .i_limit_ms(mode_duration(mode_reg)),
        .o_expired(dur_expired)
    );

    // Trip sources, each forcing the latched shutdown.
    wire op_trip = over_sample && (trip_cnt_reg == TRIP_SAMPLES - 3'h1);
    wire ref_trip = refs.valid && (refs.value == ADC_FULL);
    wire dur_trip = armed && dur_expired;
    wire force_trip = ctrl_reg[CTRL_FORCE_TRIP];
    wire trip_any = op_trip || ref_trip || dur_trip || force_trip;

    // Zero averaging over a fixed number of pressure samples.
    wire [12:0] zero_sum = zero_acc_reg + {3'b000, press.value};
    wire [9:0] zero_avg = zero_sum[ZERO_SHIFT +: 10];
    wire zero_last = (state_reg == ST_ZERO) && press.valid
                     && (zero_cnt_reg == ZERO_SAMPLES - 4'h1);
    wire zero_ok = ({1'b0, zero_avg} >= ZERO_LO_CNT) && ({1'b0, zero_avg} <= ZERO_HI_CNT);
    wire mode_valid = mode_known(i_meas_mode_code);
    wire host_reset_fall = host_rst_prev_reg && !i_host_reset_n;

    // Next state; shutdown has no exit and host reset never reaches it.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT: begin
                if (!zero_fault_reg && mode_valid && i_host_reset_n) begin
                    state_next = ST_ZERO;
                end
            end
            ST_ZERO: begin
                if (!i_host_reset_n || i_meas_mode_code != mode_reg) begin
                    state_next = ST_WAIT;
                end else if (zero_last) begin
                    state_next = zero_ok ? ST_ARMED : ST_WAIT;
                end
            end
            ST_ARMED: begin
                if (!i_host_reset_n || i_meas_mode_code != mode_reg) begin
                    state_next = ST_WAIT;
                end
            end
            ST_SHUTDOWN: state_next = ST_SHUTDOWN;
            default: state_next = ST_SHUTDOWN;
        endcase
        if (trip_any) begin
            state_next = ST_SHUTDOWN;
        end
    end

    // State register, cleared only by the supervisor's own reset.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= ST_WAIT;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // Mode capture, zero calibration and zero fault.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_reg <= MODE_IDLE;
            zero_reg <= 10'h000;
            zero_acc_reg <= 13'h0000;
            zero_cnt_reg <= 4'h0;
            zero_fault_reg <= 1'b0;
        end else if (i_ce) begin
            if (state_reg == ST_WAIT) begin
                mode_reg <= i_meas_mode_code;
                zero_acc_reg <= 13'h0000;
                zero_cnt_reg <= 4'h0;
                if (i_meas_mode_code == MODE_IDLE) begin
                    zero_fault_reg <= 1'b0;
                end
            end else if (state_reg == ST_ZERO && press.valid) begin
                zero_acc_reg <= zero_sum;
                zero_cnt_reg <= zero_cnt_reg + 4'h1;
                if (zero_last) begin
                    zero_reg <= zero_avg;
                    zero_fault_reg <= !zero_ok;
                end
            end
        end
    end

    // Consecutive over-limit count, last pressure and shutdown cause.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            trip_cnt_reg <= 3'h0;
            last_press_reg <= 10'h000;
            cause_reg <= 4'h0;
        end else if (i_ce) begin
            if (press.valid) begin
                trip_cnt_reg <= over_sample ? trip_cnt_reg + 3'h1 : 3'h0;
                last_press_reg <= press.value;
            end
            if (state_reg != ST_SHUTDOWN) begin
                cause_reg <= {force_trip, dur_trip, ref_trip, op_trip};
            end
        end
    end

    // Power-cut enable and state code; power stays cut once shut down.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_power_cut_enable_n <= 1'b1;
            o_supervisor_state_code <= CODE_NOT_READY;
            host_rst_prev_reg <= 1'b1;
        end else if (i_ce) begin
            o_power_cut_enable_n <= (state_next == ST_SHUTDOWN);
            host_rst_prev_reg <= i_host_reset_n;
            if (state_next == ST_SHUTDOWN) begin
                o_supervisor_state_code <= CODE_SHUTDOWN;
            end else if (zero_fault_reg || (zero_last && !zero_ok)) begin
                o_supervisor_state_code <= CODE_FAULT;
            end else if (state_next == ST_ARMED) begin
                o_supervisor_state_code <= mode_reg;
            end else begin
                o_supervisor_state_code <= CODE_NOT_READY;
            end
        end
    end

    // Interrupt events and register decode.
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_OVERPRESSURE] = op_trip;
        irq_events[IRQ_REF_FAIL] = ref_trip;
        irq_events[IRQ_DURATION] = dur_trip;
        irq_events[IRQ_ZERO_DONE] = zero_last && zero_ok;
        irq_events[IRQ_ZERO_FAULT] = zero_last && !zero_ok;
        irq_events[IRQ_HOST_RESET] = host_reset_fall;
    end
    wire wr_ctrl = i_reg_wr && (i_reg_addr == REG_CTRL);
    wire wr_stat = i_reg_wr && (i_reg_addr == REG_IRQ_STAT);
    wire wr_mask = i_reg_wr && (i_reg_addr == REG_IRQ_MASK);
    wire [IRQ_W-1:0] w1c = wr_stat ? i_reg_wdata[IRQ_W-1:0] : '0;
    wire [15:0] status_word = {cause_reg, o_supervisor_state_code, 6'h00, state_reg};
    wire [15:0] rd_mux =
        (i_reg_addr == REG_CTRL) ? ctrl_reg :
        (i_reg_addr == REG_STATUS) ? status_word :
        (i_reg_addr == REG_IRQ_STAT) ? {10'h000, irq_stat_reg} :
        (i_reg_addr == REG_IRQ_MASK) ? {10'h000, irq_mask_reg} :
        (i_reg_addr == REG_PRESSURE) ? {6'h00, last_press_reg} :
        (i_reg_addr == REG_ZERO) ? {6'h00, zero_reg} : 16'h0000;

    // Control, sticky status with set winning over clear, mask and read data.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg <= CTRL_RST;
            irq_stat_reg <= '0;
            irq_mask_reg <= IRQ_MASK_RST;
            o_reg_rdata <= 16'h0000;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ctrl_reg <= {15'h0000, i_reg_wdata[CTRL_FORCE_TRIP]};
            end
            if (wr_mask) begin
                irq_mask_reg <= i_reg_wdata[IRQ_W-1:0];
            end
            irq_stat_reg <= (irq_stat_reg & ~w1c) | irq_events;
            o_reg_rdata <= i_reg_rd ? rd_mux : 16'h0000;
            o_irq <= |(((irq_stat_reg & ~w1c) | irq_events) & irq_mask_reg);
        end
    end

endmodule

// ### bench/ops_supervisor_sva.sv
// Concurrent checks on the supervisor's ports.
`timescale 1ns/1ps
module ops_supervisor_sva import ops_pkg::*; #(
    parameter int unsigned PERIOD = SAMPLE_CYCLES,
    parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_host_reset_n,
    input wire logic [3:0] i_meas_mode_code,
    input wire logic [3:0] o_supervisor_state_code,
    input wire logic o_power_cut_enable_n,
    input wire adc_req_t o_adc_req,
    input wire adc_rsp_t i_adc_rsp,
    input wire logic [3:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_irq
);
    logic run_reg;
    logic seen_reg;
    logic last_ch_reg;
    int unsigned gap_reg;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // First live edge, last channel started and gap between starts.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            run_reg <= 1'b0;
            seen_reg <= 1'b0;
            last_ch_reg <= 1'b1;
            gap_reg <= 0;
        end else if (i_ce) begin
            run_reg <= 1'b1;
            gap_reg <= o_adc_req.start ? 0 : gap_reg + 1;
            seen_reg <= seen_reg | o_adc_req.start;
            last_ch_reg <= o_adc_req.start ? o_adc_req.channel : last_ch_reg;
        end
    end
    chk_cut_latched: assert property (
        run_reg && o_power_cut_enable_n |=> o_power_cut_enable_n)
        else $error("power cut released");
    chk_cut_code: assert property (
        run_reg && o_power_cut_enable_n |-> o_supervisor_state_code == CODE_SHUTDOWN)
        else $error("cut without shutdown code");
    chk_code_stuck: assert property (
        o_supervisor_state_code == CODE_SHUTDOWN |=> $stable(o_supervisor_state_code))
        else $error("shutdown code left");
    chk_host_disarm: assert property (
        i_ce && !i_host_reset_n |=> !(o_supervisor_state_code inside {4'h1, 4'h2, 4'h3}))
        else $error("armed during host reset");
    chk_sample_period: assert property (
        o_adc_req.start && seen_reg |-> gap_reg == PERIOD - 1)
        else $error("sample spacing wrong");
    chk_channel_alt: assert property (
        o_adc_req.start |-> o_adc_req.channel != last_ch_reg)
        else $error("channels not alternating");
    chk_rdata_idle: assert property (
        i_ce && !i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("read data without read");
    chk_irq_masked: assert property (
        i_ce && i_reg_wr && i_reg_addr == REG_IRQ_MASK && i_reg_wdata[5:0] == 6'h00
        |-> ##2 !o_irq)
        else $error("irq while masked");
    chk_ref_trip: assert property (
        i_adc_rsp.done && last_ch_reg && i_adc_rsp.result == ADC_FULL
        |-> ##[1:4] o_power_cut_enable_n)
        else $error("no ref shutdown");
endmodule

// ### bench/adc_model.sv
// Behavioural converter answering conversion requests.
`timescale 1ns/1ps
module adc_model import ops_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_slow,
    input wire logic [9:0] i_press,
    input wire logic [9:0] i_refv,
    input wire adc_req_t i_req,
    output adc_rsp_t o_rsp
);
    int cnt = -1;
    logic ch = 1'b0;
    initial o_rsp = '0;
    // Answers late when slow; the result bus flips between answers.
    always @(posedge i_mclk) begin
        o_rsp.done <= 1'b0;
        o_rsp.result <= ~o_rsp.result;
        if (i_req.start) begin
            ch <= i_req.channel;
            cnt <= i_slow ? 6 : 0;
        end else if (cnt == 0) begin
            o_rsp.done <= 1'b1;
            o_rsp.result <= ch ? i_refv : i_press;
            cnt <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ### bench/overpressure_safety_supervisor_tb_top.sv
// Self-checking testbench of the supervisor.
`timescale 1ns/1ps
module overpressure_safety_supervisor_tb_top import ops_pkg::*;;
    localparam int unsigned PER = 20;
    localparam int NEO_CNT = (150 * 12440 * 1024) / 5000000;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic host_n = 1'b1;
    logic [3:0] mode = 4'h0;
    logic [3:0] code;
    logic cut_n;
    adc_req_t req;
    adc_rsp_t rsp;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic irq;
    logic slow = 1'b0;
    logic [9:0] press = 10'h014;
    logic [9:0] refv = 10'h200;
    int mismatches = 0;
    int checks_done = 0;
    always #2.5 i_mclk = ~i_mclk;
    // Design under test and its converter.
    overpressure_safety_supervisor #(.PERIOD(PER), .TICK_CYCLES(10)) dut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_host_reset_n(host_n),
        .i_meas_mode_code(mode), .o_supervisor_state_code(code), .o_power_cut_enable_n(cut_n),
        .o_adc_req(req), .i_adc_rsp(rsp), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));
    adc_model conv (.i_mclk(i_mclk), .i_slow(slow), .i_press(press), .i_refv(refv),
        .i_req(req), .o_rsp(rsp));
    task results();
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task wait_code(input logic [3:0] exp);
        int n;
        n = 0;
        while (code !== exp && n < 3000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        cmp_word({12'h000, code}, {12'h000, exp});
        if (n >= 3000) results();
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_mclk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task do_reset();
        @(posedge i_mclk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
    endtask
    // Reset levels and register defaults.
    task t_reset_vals();
        logic [15:0] v;
        @(posedge i_mclk);
        #1;
        cmp_bit(cut_n, 1'b1);
        @(posedge i_mclk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        cmp_bit(cut_n, 1'b0);
        rd_reg(REG_IRQ_MASK, v);
        cmp_word(v, 16'h0000);
        rd_reg(REG_CTRL, v);
        cmp_word(v, 16'h0000);
        rd_reg(4'hF, v);
        cmp_word(v, 16'h0000);
    endtask
    // Arms each mode, then raises and clears the zero-done interrupt.
    task t_arm();
        logic [15:0] v;
        wr_reg(REG_IRQ_MASK, 16'h0008);
        for (int m = 1; m <= 3; m++) begin
            @(posedge i_mclk);
            mode <= m[3:0];
            wait_code(m[3:0]);
        end
        rd_reg(REG_ZERO, v);
        cmp_word(v, 16'h0014);
        cmp_bit(irq, 1'b1);
        wr_reg(REG_IRQ_STAT, 16'h0008);
        repeat (2) @(posedge i_mclk);
        #1;
        cmp_bit(irq, 1'b0);
        wr_reg(REG_IRQ_MASK, 16'h0000);
    endtask
    // Host reset disarms but keeps actuator power.
    task t_host();
        logic [15:0] v;
        @(posedge i_mclk);
        host_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1;
        cmp_word({12'h000, code}, 16'h0000);
        cmp_bit(cut_n, 1'b0);
        @(posedge i_mclk);
        host_n <= 1'b1;
        wait_code(MODE_NEO);
        rd_reg(REG_IRQ_STAT, v);
        cmp_word(v, 16'h0028);
        wr_reg(REG_IRQ_STAT, 16'h003F);
    endtask
    // Neonate limit edge, then a latched trip that host reset cannot release.
    task t_limit();
        logic [15:0] v;
        @(posedge i_mclk);
        press <= 10'(20 + NEO_CNT);
        repeat (12 * PER) @(posedge i_mclk);
        #1;
        cmp_word({12'h000, code}, 16'h0003);
        @(posedge i_mclk);
        press <= 10'(21 + NEO_CNT);
        wait_code(CODE_SHUTDOWN);
        cmp_bit(cut_n, 1'b1);
        @(posedge i_mclk);
        host_n <= 1'b0;
        press <= 10'h014;
        repeat (10 * PER) @(posedge i_mclk);
        host_n <= 1'b1;
        #1;
        cmp_bit(cut_n, 1'b1);
        rd_reg(REG_STATUS, v);
        cmp_word(v, 16'h1F02);
    endtask
    // Full-scale reference shuts down before arming.
    task t_ref();
        logic [15:0] v;
        @(posedge i_mclk);
        refv <= ADC_FULL;
        mode <= MODE_IDLE;
        do_reset();
        wait_code(CODE_SHUTDOWN);
        rd_reg(REG_STATUS, v);
        cmp_word(v, 16'h2F02);
    endtask
    // Bad zero with a slow converter, then a forced trip.
    task t_badzero();
        @(posedge i_mclk);
        refv <= 10'h200;
        press <= 10'h064;
        slow <= 1'b1;
        mode <= MODE_ADULT;
        do_reset();
        wait_code(CODE_FAULT);
        cmp_bit(cut_n, 1'b0);
        @(posedge i_mclk);
        mode <= MODE_IDLE;
        wait_code(CODE_NOT_READY);
        wr_reg(REG_CTRL, 16'h0001);
        wait_code(CODE_SHUTDOWN);
    endtask
    initial begin
        t_reset_vals();
        t_arm();
        t_host();
        t_limit();
        t_ref();
        t_badzero();
        results();
    end
endmodule
bind overpressure_safety_supervisor ops_supervisor_sva #(.PERIOD(PERIOD),
    .TICK_CYCLES(TICK_CYCLES)) u_sva (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_host_reset_n(i_host_reset_n), .i_meas_mode_code(i_meas_mode_code),
    .o_supervisor_state_code(o_supervisor_state_code), .o_irq(o_irq),
    .o_power_cut_enable_n(o_power_cut_enable_n), .o_adc_req(o_adc_req),
    .i_adc_rsp(i_adc_rsp), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
